// file: design/prio_pkg.sv
package prio_pkg;
  localparam int NUM_REGS = 6;
  localparam int NUM_SRC = 20;
  localparam int REG_W = 16;
  localparam int PRIO_W = 3;
  localparam int ADDR_W = 4;
  localparam int EN_HI_W = 4;

  // register indices on the plain port
  localparam logic [3:0] IDX_PRIO_2 = 4'h0;
  localparam logic [3:0] IDX_PRIO_7 = 4'h5;
  localparam logic [3:0] IDX_EN_LO = 4'h6;
  localparam logic [3:0] IDX_EN_HI = 4'h7;
  localparam logic [3:0] IDX_REQ_LO = 4'h8;
  localparam logic [3:0] IDX_REQ_HI = 4'h9;

  localparam logic [2:0] PRIO_OFF = 3'h0;
  localparam logic [2:0] PRIO_LOW = 3'h1;
  localparam logic [2:0] PRIO_TOP = 3'h7;
  localparam logic [2:0] PRIO_RESET = 3'h4;
  localparam logic [15:0] FIELD_FILL = {4{1'b0, PRIO_RESET}};

  // implemented bits of priority registers 2..7
  localparam logic [15:0] IMPL_MASK [NUM_REGS] =
    '{16'h7777, 16'h0077, 16'h7777, 16'h7707, 16'h7770, 16'h7777};

  // register and field lsb of each source, in src_t order
  localparam int SRC_REG [NUM_SRC] =
    '{0, 0, 0, 0, 1, 1, 2, 2, 2, 2, 3, 3, 3, 4, 4, 4, 5, 5, 5, 5};
  localparam int SRC_LSB [NUM_SRC] =
    '{12, 8, 4, 0, 4, 0, 12, 8, 4, 0, 12, 8, 0, 12, 8, 4, 12, 8, 4, 0};

  typedef enum int {
    SERIAL1_RX, SPI1_EVENT, SPI1_FAULT, TIMER_THREE,
    ADC_DONE, SERIAL1_TX,
    CHANGE_NOTIFY, COMPARATOR, I2C1_MASTER, I2C1_SLAVE,
    CAPTURE_CH8, CAPTURE_CH7, EXT_PIN1,
    TIMER_FOUR, COMPARE_CH4, COMPARE_CH3,
    SERIAL2_TX, SERIAL2_RX, EXT_PIN2, TIMER_FIVE
  } src_t;

  typedef logic [NUM_REGS-1:0][REG_W-1:0] bank_t;
  typedef logic [NUM_SRC-1:0][PRIO_W-1:0] prio_vec_t;

  function automatic logic [2:0] field_of(bank_t b, int s);
    return b[SRC_REG[s]][SRC_LSB[s] +: PRIO_W];
  endfunction : field_of

  function automatic logic is_prio(logic [3:0] idx);
    return idx <= IDX_PRIO_7;
  endfunction : is_prio

  function automatic logic [15:0] mask_of(logic [3:0] idx);
    return is_prio(idx) ? IMPL_MASK[idx[2:0]] : 16'h0000;
  endfunction : mask_of
endpackage : prio_pkg

// file: design/prio_if.sv
`timescale 1ns/1ps
interface prio_if;
  logic wr;
  logic [2:0] idx;
  logic [15:0] wdata;
  prio_pkg::bank_t regs;
  prio_pkg::prio_vec_t prio;

  modport bank (input wr, input idx, input wdata, output regs, output prio);
  modport host (output wr, output idx, output wdata, input regs,
    input prio);
  modport gate (input prio);
endinterface : prio_if

// file: design/prio_bank.sv
`timescale 1ns/1ps
module prio_bank (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // register traffic and exported fields
  prio_if.bank lnk
);
  logic [15:0] mem [prio_pkg::NUM_REGS];

  for (genvar i = 0; i < prio_pkg::NUM_REGS; i++)
  begin : g_reg
    always_ff @(posedge mclk or posedge rst)
    begin
      if (rst)
        mem[i] <= prio_pkg::FIELD_FILL & prio_pkg::IMPL_MASK[i];
      else if (lnk.wr && lnk.idx == 3'(i))
        mem[i] <= lnk.wdata & prio_pkg::IMPL_MASK[i];
    end
    assign lnk.regs[i] = mem[i];
  end

  // field map per source
  always_comb
  begin
    for (int s = 0; s < prio_pkg::NUM_SRC; s++)
      lnk.prio[s] = prio_pkg::field_of(lnk.regs, s);
  end
endmodule : prio_bank

// file: design/req_gate.sv
`timescale 1ns/1ps
module req_gate (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // priorities from the bank
  prio_if.gate lnk,
  // per-source enable and pending flag
  input wire logic [19:0] enable,
  input wire logic [19:0] flag,
  // level forwarded to arbitration, zero when no request
  output prio_pkg::prio_vec_t req_level
);
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      req_level <= '0;
    else
      for (int s = 0; s < prio_pkg::NUM_SRC; s++)
        if (flag[s] && enable[s]
            && lnk.prio[s] != prio_pkg::PRIO_OFF)
          req_level[s] <= lnk.prio[s];
        else
          req_level[s] <= prio_pkg::PRIO_OFF;
  end
endmodule : req_gate

// file: design/irq_prio_bank.sv
// Local design decisions: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
module irq_prio_bank (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // register port
  input wire logic [3:0] addr,
  input wire logic [15:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [15:0] rdata,
  // pending flags from the sources
  input wire logic [19:0] src_flag,
  // levels forwarded to arbitration
  output prio_pkg::prio_vec_t req_level,
  // per-source priorities
  output logic [2:0] serial1_rx_prio,
  output logic [2:0] spi_port1_event_prio,
  output logic [2:0] spi_port1_fault_prio,
  output logic [2:0] timer_three_prio,
  output logic [2:0] adc_done_prio,
  output logic [2:0] serial1_tx_prio,
  output logic [2:0] change_notify_prio,
  output logic [2:0] comparator_prio,
  output logic [2:0] i2c_port1_master_prio,
  output logic [2:0] i2c_port1_slave_prio,
  output logic [2:0] capture_ch8_prio,
  output logic [2:0] capture_ch7_prio,
  output logic [2:0] ext_pin1_prio,
  output logic [2:0] timer_four_prio,
  output logic [2:0] compare_ch4_prio,
  output logic [2:0] compare_ch3_prio,
  output logic [2:0] serial2_tx_prio,
  output logic [2:0] serial2_rx_prio,
  output logic [2:0] ext_pin2_prio,
  output logic [2:0] timer_five_prio
);
  prio_if lnk ();

  logic [15:0] en_lo;
  logic [3:0] en_hi;
  logic [19:0] enable;
  logic [19:0] req_active;
  logic [15:0] next_rdata;

  assign enable = {en_hi, en_lo};

  // register bank writes go through the carrier
  assign lnk.wr = wr && prio_pkg::is_prio(addr);
  assign lnk.idx = addr[2:0];
  assign lnk.wdata = wdata;

  prio_bank u_bank (
    .mclk(mclk),
    .rst(rst),
    .lnk(lnk.bank)
  );

  req_gate u_gate (
    .mclk(mclk),
    .rst(rst),
    .lnk(lnk.gate),
    .enable(enable),
    .flag(src_flag),
    .req_level(req_level)
  );

  // fields leave straight from the bank flops
  assign serial1_rx_prio = lnk.prio[prio_pkg::SERIAL1_RX];
  assign spi_port1_event_prio = lnk.prio[prio_pkg::SPI1_EVENT];
  assign spi_port1_fault_prio = lnk.prio[prio_pkg::SPI1_FAULT];
  assign timer_three_prio = lnk.prio[prio_pkg::TIMER_THREE];
  assign adc_done_prio = lnk.prio[prio_pkg::ADC_DONE];
  assign serial1_tx_prio = lnk.prio[prio_pkg::SERIAL1_TX];
  assign change_notify_prio = lnk.prio[prio_pkg::CHANGE_NOTIFY];
  assign comparator_prio = lnk.prio[prio_pkg::COMPARATOR];
  assign i2c_port1_master_prio = lnk.prio[prio_pkg::I2C1_MASTER];
  assign i2c_port1_slave_prio = lnk.prio[prio_pkg::I2C1_SLAVE];
  assign capture_ch8_prio = lnk.prio[prio_pkg::CAPTURE_CH8];
  assign capture_ch7_prio = lnk.prio[prio_pkg::CAPTURE_CH7];
  assign ext_pin1_prio = lnk.prio[prio_pkg::EXT_PIN1];
  assign timer_four_prio = lnk.prio[prio_pkg::TIMER_FOUR];
  assign compare_ch4_prio = lnk.prio[prio_pkg::COMPARE_CH4];
  assign compare_ch3_prio = lnk.prio[prio_pkg::COMPARE_CH3];
  assign serial2_tx_prio = lnk.prio[prio_pkg::SERIAL2_TX];
  assign serial2_rx_prio = lnk.prio[prio_pkg::SERIAL2_RX];
  assign ext_pin2_prio = lnk.prio[prio_pkg::EXT_PIN2];
  assign timer_five_prio = lnk.prio[prio_pkg::TIMER_FIVE];

  // enable registers
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      en_lo <= 16'h0000;
    else if (wr && addr == prio_pkg::IDX_EN_LO)
      en_lo <= wdata;
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      en_hi <= 4'h0;
    else if (wr && addr == prio_pkg::IDX_EN_HI)
      en_hi <= wdata[prio_pkg::EN_HI_W-1:0];
  end

  // which sources currently forward a request
  always_comb
  begin
    for (int s = 0; s < prio_pkg::NUM_SRC; s++)
      req_active[s] = req_level[s] != prio_pkg::PRIO_OFF;
  end

  // read decode, unmapped reads return zero
  always_comb
  begin
    next_rdata = 16'h0000;
    if (prio_pkg::is_prio(addr))
      next_rdata = lnk.regs[addr[2:0]];
    else
      unique case (addr)
        prio_pkg::IDX_EN_LO: next_rdata = en_lo;
        prio_pkg::IDX_EN_HI: next_rdata = {12'h000, en_hi};
        prio_pkg::IDX_REQ_LO: next_rdata = req_active[15:0];
        prio_pkg::IDX_REQ_HI: next_rdata = {12'h000, req_active[19:16]};
        default: next_rdata = 16'h0000;
      endcase
  end

  // data stand only in the cycle after the strobe
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      rdata <= 16'h0000;
    else if (rd)
      rdata <= next_rdata;
    else
      rdata <= 16'h0000;
  end

  // checks

  logic wrote_any;

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      wrote_any <= 1'b0;
    else if (lnk.wr)
      wrote_any <= 1'b1;
  end

  default clocking cb @(posedge mclk);
  endclocking

  default disable iff (rst);

  sequence s_bank_write;
    wr && prio_pkg::is_prio(addr);
  endsequence

  sequence s_readback;
    rd && addr == $past(addr);
  endsequence

  sequence s_fresh_read;
    !wrote_any && rd && prio_pkg::is_prio(addr);
  endsequence

  a_write_readback:
    assert property (s_bank_write ##1 s_readback |=>
      rdata == ($past(wdata, 2) & prio_pkg::mask_of($past(addr, 2))))
    else $error("read back differs from last write");

  a_unimpl_zero:
    assert property (rd && prio_pkg::is_prio(addr) |=>
      (rdata & ~prio_pkg::mask_of($past(addr))) == 16'h0000)
    else $error("unimplemented bit read as one");

  a_reset_default:
    assert property (s_fresh_read |=>
      rdata == (prio_pkg::FIELD_FILL & prio_pkg::mask_of($past(addr))))
    else $error("field not at reset default");

  a_rdata_quiet:
    assert property (!rd |=> rdata == 16'h0000)
    else $error("read data outside read slot");

  // read path and enable register checks
  a_unmapped_read:
    assert property (rd && addr > prio_pkg::IDX_REQ_HI |=>
      rdata == 16'h0000)
    else $error("unmapped address read as nonzero");

  a_enable_store:
    assert property (wr && addr == prio_pkg::IDX_EN_LO |=>
      enable[15:0] == $past(wdata))
    else $error("low enable bits not stored");

  a_enable_hi_store:
    assert property (wr && addr == prio_pkg::IDX_EN_HI |=>
      enable[19:16] == $past(wdata[prio_pkg::EN_HI_W-1:0]))
    else $error("high enable bits not stored");

  a_enable_lo_read:
    assert property (rd && addr == prio_pkg::IDX_EN_LO |=>
      rdata == $past(enable[15:0]))
    else $error("low enable bits read wrong");

  a_enable_hi_read:
    assert property (rd && addr == prio_pkg::IDX_EN_HI |=>
      rdata == {12'h000, $past(enable[19:16])})
    else $error("high enable bits read wrong");

  // storage checks per register
  for (genvar k = 0; k < prio_pkg::NUM_REGS; k++)
  begin : g_reg_chk
    a_unimpl_store:
      assert property (lnk.wr && lnk.idx == 3'(k) |=>
        (lnk.regs[k] & ~prio_pkg::IMPL_MASK[k]) == 16'h0000)
      else $error("unimplemented bit stored");

    a_reg_hold:
      assert property (!(lnk.wr && lnk.idx == 3'(k)) |=>
        $stable(lnk.regs[k]))
      else $error("register changed without a write");

    a_reg_store:
      assert property (lnk.wr && lnk.idx == 3'(k) |=>
        lnk.regs[k] == ($past(lnk.wdata) & prio_pkg::IMPL_MASK[k]))
      else $error("register did not take the write");
  end

  // request path checks per source

  for (genvar s = 0; s < prio_pkg::NUM_SRC; s++)
  begin : g_chk
    localparam int R = prio_pkg::SRC_REG[s];
    localparam int L = prio_pkg::SRC_LSB[s];
    localparam logic [3:0] ACT_IDX =
      s < 16 ? prio_pkg::IDX_REQ_LO : prio_pkg::IDX_REQ_HI;
    localparam int ACT_BIT = s % 16;

    sequence s_code_write(logic [2:0] code);
      wr && addr == 4'(R) && wdata[L +: prio_pkg::PRIO_W] == code;
    endsequence

    sequence s_src_live;
      src_flag[s] && enable[s];
    endsequence

    a_field_map:
      assert property (wr && addr == 4'(R) |=>
        lnk.prio[s] == $past(wdata[L +: prio_pkg::PRIO_W]))
      else $error("field not taken from its bits");

    a_top_level:
      assert property (src_flag[s] && enable[s]
        && lnk.prio[s] == prio_pkg::PRIO_TOP |=>
        req_level[s] == prio_pkg::PRIO_TOP)
      else $error("code 111 not forwarded as level 7");

    a_low_level:
      assert property (src_flag[s] && enable[s]
        && lnk.prio[s] == prio_pkg::PRIO_LOW |=>
        req_level[s] == prio_pkg::PRIO_LOW)
      else $error("code 001 not forwarded as level 1");

    a_linear_level:
      assert property (src_flag[s] && enable[s] |=>
        req_level[s] == $past(lnk.prio[s]))
      else $error("level differs from code");

    a_disabled_src:
      assert property (lnk.prio[s] == prio_pkg::PRIO_OFF |=>
        req_level[s] == prio_pkg::PRIO_OFF)
      else $error("disabled source raised a request");

    a_enable_gate:
      assert property (!enable[s] || !src_flag[s] |=>
        req_level[s] == prio_pkg::PRIO_OFF)
      else $error("request passed a cleared enable");

    a_flag_gate:
      assert property (!src_flag[s] |=> req_level[s] == prio_pkg::PRIO_OFF)
      else $error("request raised without a pending flag");

    a_reset_field:
      assert property (!wrote_any |-> lnk.prio[s] == prio_pkg::PRIO_RESET)
      else $error("field not at reset default before first write");

    a_prompt_use:
      assert property ((wr && addr == 4'(R)) ##1 s_src_live |=>
        req_level[s] == $past(wdata[L +: prio_pkg::PRIO_W], 2))
      else $error("written priority not used next cycle");

    a_top_path:
      assert property (s_code_write(prio_pkg::PRIO_TOP) ##1 s_src_live |=>
        req_level[s] == prio_pkg::PRIO_TOP)
      else $error("written code 111 not forwarded as level 7");

    a_low_path:
      assert property (s_code_write(prio_pkg::PRIO_LOW) ##1 s_src_live |=>
        req_level[s] == prio_pkg::PRIO_LOW)
      else $error("written code 001 not forwarded as level 1");

    a_off_path:
      assert property (s_code_write(prio_pkg::PRIO_OFF) ##1 1'b1 |=>
        req_level[s] == prio_pkg::PRIO_OFF)
      else $error("written code 000 still forwards a request");

    a_active_bit:
      assert property (rd && addr == ACT_IDX |=>
        rdata[ACT_BIT] == ($past(req_level[s]) != prio_pkg::PRIO_OFF))
      else $error("request bit read wrong");

    a_field_read:
      assert property (rd && addr == 4'(R) |=>
        rdata[L +: prio_pkg::PRIO_W] == $past(lnk.prio[s]))
      else $error("read field differs from exported field");
  end
endmodule : irq_prio_bank

// file: testbench/src_model.sv
`timescale 1ns/1ps
module src_model (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // flags the bench wants raised
  input wire logic [19:0] want,
  // pending flags toward the bank
  output logic [19:0] src_flag
);
  // sources raise flags one cycle after being told, like a flag flop
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      src_flag <= '0;
    else
      src_flag <= want;
  end
endmodule : src_model

// file: testbench/test_irq_prio_bank.sv
`timescale 1ns/1ps
module test_irq_prio_bank;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic [3:0] addr = 4'h0;
  logic [15:0] wdata = 16'h0000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [15:0] rdata;
  logic [19:0] want = 20'h00000;
  logic [19:0] src_flag;
  prio_pkg::prio_vec_t req_level;
  prio_pkg::prio_vec_t outs;
  int fails = 0;
  int checks = 0;
  int cycles = 0;
  localparam logic [15:0] PAT [6] =
    '{16'hfedb, 16'hba98, 16'hf1e2, 16'hd3cb, 16'hb5a6, 16'h9786};

  initial
  begin
    forever #2 mclk = ~mclk;
  end

  src_model partner (.mclk(mclk), .rst(rst), .want(want),
    .src_flag(src_flag));

  irq_prio_bank DUT (.mclk(mclk), .rst(rst), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .src_flag(src_flag),
    .req_level(req_level),
    .serial1_rx_prio(outs[0]), .spi_port1_event_prio(outs[1]),
    .spi_port1_fault_prio(outs[2]), .timer_three_prio(outs[3]),
    .adc_done_prio(outs[4]), .serial1_tx_prio(outs[5]),
    .change_notify_prio(outs[6]), .comparator_prio(outs[7]),
    .i2c_port1_master_prio(outs[8]), .i2c_port1_slave_prio(outs[9]),
    .capture_ch8_prio(outs[10]), .capture_ch7_prio(outs[11]),
    .ext_pin1_prio(outs[12]), .timer_four_prio(outs[13]),
    .compare_ch4_prio(outs[14]), .compare_ch3_prio(outs[15]),
    .serial2_tx_prio(outs[16]), .serial2_rx_prio(outs[17]),
    .ext_pin2_prio(outs[18]), .timer_five_prio(outs[19]));

  task automatic end_of_test;
    if (fails == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : end_of_test

  always @(posedge mclk)
  begin
    cycles <= cycles + 1;
    if (cycles == 5000)
    begin
      fails = fails + 1;
      end_of_test();
    end
  end

  task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
    checks = checks + 1;
    if (got !== exp)
    begin
      fails = fails + 1;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk16

  task automatic chk3(input logic [2:0] got, input logic [2:0] exp);
    checks = checks + 1;
    if (got !== exp)
    begin
      fails = fails + 1;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk3

  task automatic reg_wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge mclk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge mclk);
    wr <= 1'b0;
  endtask : reg_wr

  // read data lands with the edge that ends the strobe cycle
  task automatic reg_rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge mclk);
    rd <= 1'b1;
    addr <= a;
    @(posedge mclk);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask : reg_rd

  task automatic do_reset;
    rst <= 1'b1;
    repeat (12) @(posedge mclk);
    rst <= 1'b0;
  endtask : do_reset

  task automatic test_reset_values;
    logic [15:0] got;
    for (int r = 0; r < 6; r++)
    begin
      reg_rd(4'(r), got);
      chk16(got, prio_pkg::IMPL_MASK[r] & prio_pkg::FIELD_FILL);
    end
    for (int s = 0; s < 20; s++)
      chk3(outs[s], prio_pkg::PRIO_RESET);
  endtask : test_reset_values

  task automatic test_layout;
    logic [15:0] got;
    logic [2:0] exp3;
    for (int r = 0; r < 6; r++)
      reg_wr(4'(r), PAT[r]);
    @(posedge mclk);
    #1;
    for (int s = 0; s < 20; s++)
    begin
      exp3 = PAT[prio_pkg::SRC_REG[s]][prio_pkg::SRC_LSB[s] +: 3];
      chk3(outs[s], exp3);
    end
    for (int r = 0; r < 6; r++)
    begin
      reg_rd(4'(r), got);
      chk16(got, PAT[r] & prio_pkg::IMPL_MASK[r]);
      @(posedge mclk);
      #1;
      chk16(rdata, 16'h0000);
    end
  endtask : test_layout

  task automatic test_codes;
    reg_wr(4'h6, 16'hffff);
    reg_wr(4'h7, 16'h000f);
    want <= 20'hfffff;
    for (int c = 0; c < 8; c++)
    begin
      reg_wr(4'h0, {4{1'b0, 3'(c)}});
      repeat (1) @(posedge mclk);
      #1;
      for (int s = 0; s < 4; s++)
        chk3(req_level[s], 3'(c));
    end
  endtask : test_codes

  task automatic test_enable_block;
    logic [15:0] got;
    reg_wr(4'h0, 16'h5555);
    reg_wr(4'h6, 16'hfffe);
    want <= 20'hffffb;
    repeat (3) @(posedge mclk);
    #1;
    chk3(req_level[0], 3'h0);
    chk3(req_level[1], 3'h5);
    chk3(req_level[2], 3'h0);
    reg_rd(prio_pkg::IDX_EN_LO, got);
    chk16(got, 16'hfffe);
    reg_rd(prio_pkg::IDX_EN_HI, got);
    chk16(got, 16'h000f);
    reg_rd(prio_pkg::IDX_REQ_LO, got);
    chk16(got, 16'hffda);
    reg_rd(prio_pkg::IDX_REQ_HI, got);
    chk16(got, 16'h000b);
  endtask : test_enable_block

  task automatic test_unmapped;
    logic [15:0] got;
    reg_wr(4'h1, 16'hff55);
    reg_wr(4'ha, 16'hffff);
    reg_rd(4'ha, got);
    chk16(got, 16'h0000);
    reg_rd(4'h1, got);
    chk16(got, 16'h0055 & prio_pkg::IMPL_MASK[1]);
    reg_rd(4'h2, got);
    chk16(got, PAT[2] & prio_pkg::IMPL_MASK[2]);
  endtask : test_unmapped

  // write strobe followed by a read strobe with no idle cycle
  task automatic test_back_to_back;
    @(posedge mclk);
    wr <= 1'b1;
    addr <= 4'h2;
    wdata <= 16'h8421;
    @(posedge mclk);
    wr <= 1'b0;
    rd <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    #1;
    chk16(rdata, 16'h8421 & prio_pkg::IMPL_MASK[2]);
    chk3(outs[prio_pkg::I2C1_MASTER], 3'h2);
  endtask : test_back_to_back

  initial
  begin
    do_reset();
    test_reset_values();
    test_layout();
    test_codes();
    test_enable_block();
    test_unmapped();
    test_back_to_back();
    @(posedge mclk);
    do_reset();
    test_reset_values();
    end_of_test();
  end
endmodule : test_irq_prio_bank
